//--- timer_consts.svh
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_FLAGS 8'h08
`define OFS_CNT_HI 8'h0c
`define OFS_CNT_LO 8'h10
`define OFS_ALT_HI 8'h14
`define OFS_ALT_LO 8'h18
`define OFS_CMP1_HI 8'h1c
`define OFS_CMP1_LO 8'h20
`define OFS_CMP2_HI 8'h24
`define OFS_CMP2_LO 8'h28
`define OFS_CAP1_HI 8'h2c
`define OFS_CAP1_LO 8'h30
`define OFS_CAP2_HI 8'h34
`define OFS_CAP2_LO 8'h38

// ----------------------------------------
// Flag vector positions and status bits
// ----------------------------------------
`define FLG_CMP1 0
`define FLG_CMP2 1
`define FLG_CAP1 2
`define FLG_CAP2 3
`define STS_CAP1 7
`define STS_CMP1 6
`define STS_CAP2 4
`define STS_CMP2 3

// ----------------------------------------
// Reset and reload values
// ----------------------------------------
`define RST_COUNT 16'hfffc
`define ONE_PULSE_CAPTURE 16'hfffd
`define RST_COMPARE 16'h8000

// ----------------------------------------
// Clock select codes and prescaler masks
// ----------------------------------------
`define CLK_DIV2 2'h0
`define CLK_DIV4 2'h1
`define CLK_DIV8 2'h2
`define CLK_EXT 2'h3
`define MASK_DIV2 3'h1
`define MASK_DIV4 3'h3
`define MASK_DIV8 3'h7

`endif

//--- timer_pkg.sv
package timer_pkg;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_level_two;
    logic force_level_one;
    logic compare_level_two;
    logic capture_edge_select;
    logic compare_level_one;
  } control_reg_one_t;

  typedef struct packed {
    logic compare_pin_enable_one;
    logic compare_pin_enable_two;
    logic single_shot_select;
    logic pwm_select;
    logic [1:0] clock_select;
    logic capture_edge_select_two;
    logic ext_edge_select;
  } control_reg_two_t;

  typedef enum logic [1:0] {
    mode_compare,
    mode_one_pulse,
    mode_pwm
  } timer_mode_t;

endpackage : timer_pkg

//--- pin_edge.sv
`timescale 1ns/100ps

module pin_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic rising_sel,
  output logic hit
);

  logic prev;
  logic primed;

  // The first sample after reset only primes the history, so a pin that is
  // already high does not look like an edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev <= 1'b0;
      primed <= 1'b0;
    end
    else
    begin
      prev <= pin;
      primed <= 1'b1;
    end
  end

  assign hit = primed & (rising_sel ? (pin & ~prev) : (~pin & prev));

endmodule : pin_edge

//--- compare_channel.sv
`timescale 1ns/100ps
`include "timer_consts.svh"

module compare_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  input wire logic [15:0] count,
  input wire logic count_new,
  input wire logic at_equal,
  output logic [15:0] value,
  output logic inhibited,
  output logic match
);

  logic [15:0] target;

  // R23: reset value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      value <= `RST_COMPARE;
    else if (wr_high)
      value[15:8] <= wdata;
    else if (wr_low)
      value[7:0] <= wdata;
  end

  // R05: high write inhibits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inhibited <= 1'b0;
    else if (wr_high)
      inhibited <= 1'b1;
    else if (wr_low)
      inhibited <= 1'b0;
  end

  // R08: equal or plus one.
  assign target = at_equal ? value : value + 16'h0001;
  assign match = count_new & ~inhibited & (count == target);

  a_inhibit_hold: assert property (@(posedge pclk) disable iff (!presetn) // R05
    wr_high ##1 !wr_low [*2] |-> !match)
    else $error("compare matched while inhibited");

endmodule : compare_channel

//--- timer_compare_pulse_pwm.sv
`timescale 1ns/100ps
`include "timer_consts.svh"

// Behaviour
// R01: Counter match sets channel compare flag and drives pin to compare level.
// R02: Compare pin output latches are low during reset.
// R03: Compare interrupt needs compare interrupt enable set and global mask clear.
// R04: Flag clears after status read while set, then low compare byte access.
// R05: High compare byte write inhibits compares until low byte written.
// R06: Software writes high byte, reads status, then writes low byte.
// R07: Disabled pin stays general I/O; flag and interrupt still work.
// R08: Divide-by-2 updates at equality; slower clocks update at value plus one.
// R09: Force bit copies level to enabled pin, no flag, no interrupt.
// R10: Force bits do nothing in one-pulse or PWM mode.
// R11: Single-shot select enables one-pulse using capture one and compare one.
// R12: Trigger edge reloads FFFCh, drives level two, sets flag, captures FFFDh.
// R13: One-pulse trigger flag requests interrupt when capture interrupt enabled.
// R14: One-pulse match with compare one drives level one, ending pulse.
// R15: One-pulse never sets compare flag one; channel two flags only.
// R16: PWM and single-shot both set means PWM only.
// R17: One-pulse: capture one does not capture; capture two still works.
// R18: PWM match with compare two reloads counter to FFFCh.
// R19: PWM: compare one match gives level one, compare two gives level two.
// R20: PWM sets no compare flags, so no compare interrupt.
// R21: PWM compare two match sets capture flag one, interrupt if enabled.
// R22: PWM disconnects capture pin one; capture two keeps working.
// R23: Any reset loads each compare value with 8000h.
// R24: Counter low or alternate low write reloads FFFCh, also reset value.
// R25: Clock select picks divide by 2, 4, 8, or external clock.
module timer_compare_pulse_pwm #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_mask,
  input wire logic capture_in_pin_one,
  input wire logic capture_in_pin_two,
  input wire logic ext_clock_in,
  output logic [1:0] compare_out_pin,
  output logic [1:0] compare_pin_drive,
  output logic timer_irq
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W != 8)
    $error("ADDR_W must be 8");

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  timer_pkg::control_reg_one_t control_reg_one;
  timer_pkg::control_reg_two_t control_reg_two;
  timer_pkg::timer_mode_t mode;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [15:0] count;
  logic count_new;
  logic [2:0] div;
  logic tick;
  logic [2:0] div_mask;
  logic ext_hit;
  logic cap1_raw;
  logic cap1_hit;
  logic cap2_hit;
  logic [15:0] cmp1_value;
  logic [15:0] cmp2_value;
  logic cmp1_inhibited;
  logic cmp2_inhibited;
  logic match1;
  logic match2;
  logic reload;
  logic [15:0] cap1_value;
  logic [15:0] cap2_value;
  logic [3:0] flag;
  logic [3:0] armed;
  logic [3:0] flag_set;
  logic [3:0] low_access;
  logic [7:0] status_byte;
  logic status_read;
  logic at_equal;

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `OFS_CAP2_LO);
  assign pslverr = access & ~mapped;
  assign status_read = rd && (paddr == `OFS_FLAGS);

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`STS_CAP1] = flag[`FLG_CAP1];
    status_byte[`STS_CMP1] = flag[`FLG_CMP1];
    status_byte[`STS_CAP2] = flag[`FLG_CAP2];
    status_byte[`STS_CMP2] = flag[`FLG_CMP2];
  end

  always_comb
  begin
    case (paddr)
      `OFS_CTRL_ONE: rd_byte = control_reg_one;
      `OFS_CTRL_TWO: rd_byte = control_reg_two;
      `OFS_FLAGS: rd_byte = status_byte;
      `OFS_CNT_HI: rd_byte = count[15:8];
      `OFS_CNT_LO: rd_byte = count[7:0];
      `OFS_ALT_HI: rd_byte = count[15:8];
      `OFS_ALT_LO: rd_byte = count[7:0];
      `OFS_CMP1_HI: rd_byte = cmp1_value[15:8];
      `OFS_CMP1_LO: rd_byte = cmp1_value[7:0];
      `OFS_CMP2_HI: rd_byte = cmp2_value[15:8];
      `OFS_CMP2_LO: rd_byte = cmp2_value[7:0];
      `OFS_CAP1_HI: rd_byte = cap1_value[15:8];
      `OFS_CAP1_LO: rd_byte = cap1_value[7:0];
      `OFS_CAP2_HI: rd_byte = cap2_value[15:8];
      `OFS_CAP2_LO: rd_byte = cap2_value[7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is latched in the setup cycle so that the access phase can
  // complete without a wait state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h000000, rd_byte};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_reg_one <= '0;
    else if (wr && paddr == `OFS_CTRL_ONE)
      control_reg_one <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_reg_two <= '0;
    else if (wr && paddr == `OFS_CTRL_TWO)
      control_reg_two <= wbyte;
  end

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  // R16: PWM has priority.
  always_comb
  begin
    if (control_reg_two.pwm_select)
      mode = timer_pkg::mode_pwm;
    else if (control_reg_two.single_shot_select)
      mode = timer_pkg::mode_one_pulse;
    else
      mode = timer_pkg::mode_compare;
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  // R25: clock select decode.
  always_comb
  begin
    case (control_reg_two.clock_select)
      `CLK_DIV2: div_mask = `MASK_DIV2;
      `CLK_DIV4: div_mask = `MASK_DIV4;
      default: div_mask = `MASK_DIV8;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  pin_edge u_ext_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_clock_in),
    .rising_sel(control_reg_two.ext_edge_select),
    .hit(ext_hit)
  );

  assign tick = (control_reg_two.clock_select == `CLK_EXT) ? ext_hit
              : ((div & div_mask) == div_mask);
  assign at_equal = (control_reg_two.clock_select == `CLK_DIV2);

  // R24: counter write reload.
  // R12: trigger reload.
  // R18: period reload.
  assign reload = (wr && (paddr == `OFS_CNT_LO || paddr == `OFS_ALT_LO))
                | ((mode == timer_pkg::mode_one_pulse) & cap1_raw)
                | ((mode == timer_pkg::mode_pwm) & match2);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= `RST_COUNT;
    else if (reload)
      count <= `RST_COUNT;
    else if (tick)
      count <= count + 16'h0001;
  end

  // A new count value is compared once, in the cycle after it is loaded, so
  // a slow timer clock cannot raise the same match several times.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_new <= 1'b0;
    else
      count_new <= reload | tick;
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  compare_channel u_cmp1 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_high(wr && paddr == `OFS_CMP1_HI),
    .wr_low(wr && paddr == `OFS_CMP1_LO),
    .wdata(wbyte),
    .count(count),
    .count_new(count_new),
    .at_equal(at_equal),
    .value(cmp1_value),
    .inhibited(cmp1_inhibited),
    .match(match1)
  );

  compare_channel u_cmp2 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_high(wr && paddr == `OFS_CMP2_HI),
    .wr_low(wr && paddr == `OFS_CMP2_LO),
    .wdata(wbyte),
    .count(count),
    .count_new(count_new),
    .at_equal(at_equal),
    .value(cmp2_value),
    .inhibited(cmp2_inhibited),
    .match(match2)
  );

  // ----------------------------------------
  // Capture pins
  // ----------------------------------------
  pin_edge u_cap1_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_in_pin_one),
    .rising_sel(control_reg_one.capture_edge_select),
    .hit(cap1_raw)
  );

  pin_edge u_cap2_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_in_pin_two),
    .rising_sel(control_reg_two.capture_edge_select_two),
    .hit(cap2_hit)
  );

  // R22: pin one disconnected in PWM.
  assign cap1_hit = cap1_raw & (mode != timer_pkg::mode_pwm);

  // R12: trigger loads fixed value.
  // R17: no real capture on pin one in one-pulse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap1_value <= 16'h0000;
    else if (cap1_hit && mode == timer_pkg::mode_one_pulse)
      cap1_value <= `ONE_PULSE_CAPTURE;
    else if (cap1_hit)
      cap1_value <= count;
  end

  // R22: capture two always works.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap2_value <= 16'h0000;
    else if (cap2_hit)
      cap2_value <= count;
  end

  // ----------------------------------------
  // Compare output latches
  // ----------------------------------------
  // R02: latches reset low.
  // R11: one-pulse uses channel one.
  // R07: disabled pin is left alone.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_out_pin[0] <= 1'b0;
    else if (control_reg_two.compare_pin_enable_one)
    begin
      case (mode)
        // R19: PWM levels.
        timer_pkg::mode_pwm:
          if (match2)
            compare_out_pin[0] <= control_reg_one.compare_level_two;
          else if (match1)
            compare_out_pin[0] <= control_reg_one.compare_level_one;
        // R14: trigger starts, match ends pulse.
        timer_pkg::mode_one_pulse:
          if (cap1_hit)
            compare_out_pin[0] <= control_reg_one.compare_level_two;
          else if (match1)
            compare_out_pin[0] <= control_reg_one.compare_level_one;
        // R01: match drives level.
        // R09: force copies level.
        default:
          if (match1 || control_reg_one.force_level_one)
            compare_out_pin[0] <= control_reg_one.compare_level_one;
      endcase
    end
  end

  // R10: force only in compare mode.
  // R15: no waveform on channel two in the special modes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_out_pin[1] <= 1'b0;
    else if (control_reg_two.compare_pin_enable_two && mode == timer_pkg::mode_compare)
    begin
      if (match2 || control_reg_one.force_level_two)
        compare_out_pin[1] <= control_reg_one.compare_level_two;
    end
  end

  assign compare_pin_drive = {control_reg_two.compare_pin_enable_two,
                              control_reg_two.compare_pin_enable_one};

  // ----------------------------------------
  // Flags and interrupt
  // ----------------------------------------
  // R15: channel one flag off in one-pulse.
  // R20: no compare flags in PWM.
  // R21: period match sets capture flag one.
  // R13: trigger sets capture flag one.
  always_comb
  begin
    flag_set[`FLG_CMP1] = match1 & (mode == timer_pkg::mode_compare);
    flag_set[`FLG_CMP2] = match2 & (mode != timer_pkg::mode_pwm);
    flag_set[`FLG_CAP1] = cap1_hit | (match2 & (mode == timer_pkg::mode_pwm));
    flag_set[`FLG_CAP2] = cap2_hit;
    low_access[`FLG_CMP1] = access && paddr == `OFS_CMP1_LO;
    low_access[`FLG_CMP2] = access && paddr == `OFS_CMP2_LO;
    low_access[`FLG_CAP1] = access && paddr == `OFS_CAP1_LO;
    low_access[`FLG_CAP2] = access && paddr == `OFS_CAP2_LO;
  end

  // R04: two-step clear, set wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag <= 4'h0;
      armed <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (flag_set[i])
          flag[i] <= 1'b1;
        else if (armed[i] && low_access[i])
          flag[i] <= 1'b0;
        if (low_access[i])
          armed[i] <= 1'b0;
        else if (status_read && flag[i])
          armed[i] <= 1'b1;
      end
    end
  end

  // R03: compare interrupt gating.
  assign timer_irq = ~irq_mask
    & ((control_reg_one.compare_irq_enable & (flag[`FLG_CMP1] | flag[`FLG_CMP2]))
    | (control_reg_one.capture_irq_enable & (flag[`FLG_CAP1] | flag[`FLG_CAP2])));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_trigger;
    mode == timer_pkg::mode_one_pulse && cap1_hit;
  endsequence

  sequence s_period;
    mode == timer_pkg::mode_pwm && match2;
  endsequence

  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn) // R01
    mode == timer_pkg::mode_compare && match1 |=> flag[`FLG_CMP1])
    else $error("compare match did not set flag one");

  a_match_pin: assert property (@(posedge pclk) disable iff (!presetn) // R01
    mode == timer_pkg::mode_compare && match1 && control_reg_two.compare_pin_enable_one
    |=> compare_out_pin[0] == $past(control_reg_one.compare_level_one))
    else $error("compare match did not drive level one");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // R03
    irq_mask |-> !timer_irq)
    else $error("interrupt raised while masked");

  a_flag_keep: assert property (@(posedge pclk) disable iff (!presetn) // R04
    flag[`FLG_CMP1] && !armed[`FLG_CMP1] |=> flag[`FLG_CMP1])
    else $error("flag cleared without status read");

  a_force_copy: assert property (@(posedge pclk) disable iff (!presetn) // R09
    mode == timer_pkg::mode_compare && control_reg_one.force_level_one
    && control_reg_two.compare_pin_enable_one && !flag[`FLG_CMP1] && !match1
    |=> compare_out_pin[0] == $past(control_reg_one.compare_level_one) && !flag[`FLG_CMP1])
    else $error("force did not copy level quietly");

  a_opm_trigger: assert property (@(posedge pclk) disable iff (!presetn) // R12
    s_trigger |=> count == `RST_COUNT && cap1_value == `ONE_PULSE_CAPTURE
    && flag[`FLG_CAP1])
    else $error("one-pulse trigger effects missing");

  a_pwm_reload: assert property (@(posedge pclk) disable iff (!presetn) // R18
    s_period |=> count == `RST_COUNT ##1 flag[`FLG_CAP1] || $past(low_access[`FLG_CAP1], 1))
    else $error("period match did not reload counter");

  a_pwm_noflag: assert property (@(posedge pclk) disable iff (!presetn) // R20
    mode == timer_pkg::mode_pwm && !flag[`FLG_CMP2] |=> !flag[`FLG_CMP2])
    else $error("compare flag set in pwm mode");

  a_count_write: assert property (@(posedge pclk) disable iff (!presetn) // R24
    wr && paddr == `OFS_CNT_LO |=> count == `RST_COUNT)
    else $error("counter write did not reload");

endmodule : timer_compare_pulse_pwm

//--- pin_partner.sv
`timescale 1ns/100ps

// ----------------------------------------
// Board circuitry on the compare and capture pins
// ----------------------------------------
module pin_partner (
  input wire logic pclk,
  input wire logic [1:0] compare_out_pin,
  input wire logic [1:0] compare_pin_drive,
  output logic capture_in_pin_one,
  output logic capture_in_pin_two,
  output logic ext_clock_in,
  output logic [1:0] pad
);
  // A released pad is pulled down, so a stale latch value never shows.
  assign pad = compare_out_pin & compare_pin_drive;

  initial
  begin
    capture_in_pin_one = 1'b0;
    capture_in_pin_two = 1'b0;
    ext_clock_in = 1'b0;
  end

  // One clean transition, launched just after a clock edge.
  task toggle_one();
    @(posedge pclk);
    capture_in_pin_one <= ~capture_in_pin_one;
  endtask : toggle_one

  // Active edges stay four clocks apart, slow enough for the timer to follow.
  task ext_pulses(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge pclk);
      ext_clock_in <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_clock_in <= 1'b0;
    end
  endtask : ext_pulses
endmodule : pin_partner

//--- test_timer_compare_pulse_pwm.sv
`timescale 1ns/100ps
`include "timer_consts.svh"

module test_timer_compare_pulse_pwm;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_mask = 1'b0;
  logic cap_one;
  logic cap_two;
  logic ext_clk;
  logic [1:0] out_pin;
  logic [1:0] pin_drive;
  logic [1:0] pad;
  logic timer_irq;
  logic [7:0] rd;
  logic slv_err;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  always #20 pclk = ~pclk;

  timer_compare_pulse_pwm u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_mask(irq_mask), .capture_in_pin_one(cap_one),
    .capture_in_pin_two(cap_two), .ext_clock_in(ext_clk), .compare_out_pin(out_pin),
    .compare_pin_drive(pin_drive), .timer_irq(timer_irq));

  pin_partner u_partner (.pclk(pclk), .compare_out_pin(out_pin),
    .compare_pin_drive(pin_drive), .capture_in_pin_one(cap_one),
    .capture_in_pin_two(cap_two), .ext_clock_in(ext_clk), .pad(pad));

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Polls the status register until the masked bits show up, within a bound.
  task wait_status(input logic [7:0] m);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `OFS_FLAGS, 8'h00);
      n++;
    end
    while ((rd & m) !== m && n < 100);
  endtask : wait_status

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_reset();
    chk({6'h0, out_pin}, 8'h00);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CMP1_HI, 8'h00);
    chk(rd, 8'h80);
    apb(1'b0, `OFS_CMP2_LO, 8'h00);
    chk(rd, 8'h00);
    apb(1'b0, 8'h3c, 8'h00);
    chk({rd[6:0], slv_err}, 8'h01);
    $display("test_reset done");
  endtask : test_reset

  task test_compare();
    apb(1'b1, `OFS_CTRL_TWO, 8'h80);
    apb(1'b1, `OFS_CTRL_ONE, 8'h41);
    // high byte, status read, low byte.
    apb(1'b1, `OFS_CMP1_HI, 8'h00);
    apb(1'b1, `OFS_CNT_LO, 8'h00);
    repeat (40) @(posedge pclk);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd, 8'h00);
    apb(1'b1, `OFS_CMP1_LO, 8'h30);
    wait_status(8'h40);
    chk(rd, 8'h40);
    chk({6'h0, pad}, 8'h01);
    chk({7'h0, timer_irq}, 8'h01);
    irq_mask <= 1'b1;
    @(posedge pclk);
    chk({7'h0, timer_irq}, 8'h00);
    apb(1'b0, `OFS_CMP1_LO, 8'h00);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd, 8'h00);
    irq_mask <= 1'b0;
    $display("test_compare done");
  endtask : test_compare

  task test_force();
    apb(1'b1, `OFS_CTRL_TWO, 8'hc0);
    apb(1'b1, `OFS_CTRL_ONE, 8'h1c);
    repeat (2) @(posedge pclk);
    chk({6'h0, pad}, 8'h02);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd, 8'h00);
    apb(1'b1, `OFS_CTRL_TWO, 8'h00);
    apb(1'b1, `OFS_CTRL_ONE, 8'h18);
    repeat (2) @(posedge pclk);
    chk({4'h0, pin_drive, out_pin}, 8'h02);
    $display("test_force done");
  endtask : test_force

  task test_one_pulse();
    apb(1'b1, `OFS_CTRL_TWO, 8'ha0);
    apb(1'b1, `OFS_CTRL_ONE, 8'h9f);
    apb(1'b1, `OFS_CMP1_HI, 8'h00);
    apb(1'b1, `OFS_CMP1_LO, 8'h08);
    chk({6'h0, pad}, 8'h00);
    apb(1'b1, `OFS_CTRL_ONE, 8'h9e);
    u_partner.toggle_one();
    repeat (4) @(posedge pclk);
    chk({7'h0, pad[0]}, 8'h01);
    chk({7'h0, timer_irq}, 8'h01);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd & 8'h80, 8'h80);
    apb(1'b0, `OFS_CAP1_HI, 8'h00);
    chk(rd, 8'hff);
    apb(1'b0, `OFS_CAP1_LO, 8'h00);
    chk(rd, 8'hfd);
    repeat (30) @(posedge pclk);
    chk({7'h0, pad[0]}, 8'h00);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd & 8'h40, 8'h00);
    $display("test_one_pulse done");
  endtask : test_one_pulse

  task test_pwm();
    apb(1'b1, `OFS_CTRL_ONE, 8'h04);
    apb(1'b1, `OFS_CMP2_HI, 8'h00);
    apb(1'b1, `OFS_CMP2_LO, 8'h10);
    apb(1'b1, `OFS_CMP1_HI, 8'h00);
    apb(1'b1, `OFS_CMP1_LO, 8'h04);
    apb(1'b1, `OFS_CTRL_TWO, 8'hb0);
    apb(1'b1, `OFS_ALT_LO, 8'h00);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    apb(1'b0, `OFS_CAP1_LO, 8'h00);
    wait_status(8'h80);
    chk(rd & 8'h48, 8'h00);
    chk(rd & 8'h80, 8'h80);
    chk({7'h0, pad[0]}, 8'h01);
    repeat (24) @(posedge pclk);
    chk({7'h0, pad[0]}, 8'h00);
    u_partner.toggle_one();
    apb(1'b0, `OFS_CAP1_LO, 8'h00);
    chk(rd, 8'hfd);
    $display("test_pwm done");
  endtask : test_pwm

  task test_ext_clock();
    apb(1'b1, `OFS_CTRL_TWO, 8'h0c);
    apb(1'b1, `OFS_CNT_LO, 8'h00);
    u_partner.ext_pulses(6);
    repeat (2) @(posedge pclk);
    apb(1'b0, `OFS_CNT_LO, 8'h00);
    chk(rd, 8'h02);
    $display("test_ext_clock done");
  endtask : test_ext_clock

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // The whole run needs a few hundred cycles; the ceiling leaves ample room.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    test_reset();
    test_compare();
    test_force();
    test_one_pulse();
    test_pwm();
    test_ext_clock();
    tally_and_finish();
  end
endmodule : test_timer_compare_pulse_pwm
